// ===== hdl/gls_idle_counter.v
`include "gls_map.vh"
module gls_idle_counter (
	// clock and reset
	input  wire       clk,
	input  wire       arst_n,
	// count qualifiers
	input  wire       count_enable,
	input  wire       symbol_error,
	// clear sources
	input  wire       read_clear,
	input  wire       pcs_reset,
	// counter value
	output reg  [7:0] count
);
	reg [7:0] next_count;

	always @* begin
		next_count = count;
		if (count_enable && symbol_error && count != `GLS_CNT_FULL) begin
			next_count = count + 8'h01;
		end
		// a read returns the old value and starts from zero; an error in that cycle is dropped
		if (read_clear || pcs_reset) begin
			next_count = `GLS_CNT_ZERO;
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= `GLS_CNT_ZERO;
		end else begin
			count <= next_count;
		end
	end
endmodule // gls_idle_counter

// ===== hdl/gls_map.vh
`ifndef GLS_MAP_VH
`define GLS_MAP_VH
// register addresses on the management port
`define GLS_ADDR_LINK_STATUS   5'h0a
`define GLS_ADDR_EXT_CAP       5'h0f
`define GLS_ADDR_CTRL          5'h09
// gigabit_link_status fields
`define GLS_BIT_FAULT          15
`define GLS_BIT_ROLE           14
`define GLS_BIT_LOC_RX         13
`define GLS_BIT_REM_RX         12
`define GLS_BIT_LP_FD          11
`define GLS_BIT_LP_HD          10
`define GLS_CNT_MSB            7
// control register fields for manual role
`define GLS_BIT_MAN_EN         12
`define GLS_BIT_MAN_VAL        11
// failed resolutions that latch the fault
`define GLS_FAIL_LIMIT         3'h7
`define GLS_FAIL_ZERO          3'h0
`define GLS_CNT_ZERO           8'h00
`define GLS_CNT_FULL           8'hff
`define GLS_DATA_ZERO          16'h0000
`define GLS_EXT_NIBBLE_LSB     12
`endif

// ===== hdl/gls_status.v
`include "gls_map.vh"
module gls_status (
	// clock and reset
	input  wire        clk,
	input  wire        arst_n,
	// management access
	input  wire        mgmt_rd,
	input  wire        mgmt_wr,
	input  wire [4:0]  mgmt_addr,
	input  wire [15:0] mgmt_wdata,
	output reg  [15:0] mgmt_rdata,
	output reg         mgmt_rvalid,
	// resets and auto-negotiation events, same clock
	input  wire        pma_reset,
	input  wire        pcs_reset,
	input  wire        an_enable,
	input  wire        an_complete,
	input  wire        page_received,
	// role resolution, same clock
	input  wire        resolve_done,
	input  wire        resolve_fail,
	input  wire        resolved_leader,
	input  wire        partner_manual_en,
	input  wire        partner_manual_leader,
	input  wire        extra_fault,
	// receiver and partner status, from pins
	input  wire        loc_rcvr_ok,
	input  wire        rem_rcvr_ok,
	input  wire        partner_gig_full_duplex_able,
	input  wire        partner_gig_half_duplex_able,
	// receive path, same clock
	input  wire        receiving_idle,
	input  wire        transmit_mode_indication,
	input  wire        rx_symbol_error,
	input  wire [3:0]  ext_status_nibble,
	// role configuration out
	output reg         manual_role_en,
	output reg         manual_role_leader,
	output reg         role_leader,
	output reg         role_fault
);
	// synchronised pin levels
	wire [3:0]  pin_sync;
	wire        loc_ok_s;
	wire        rem_ok_s;
	wire        lp_full_s;
	wire        lp_half_s;

	// state and next values
	wire [7:0]  idle_count;
	reg         an_enable_d;
	reg         an_complete_d;
	reg  [2:0]  fail_count;
	reg  [2:0]  next_fail_count;
	reg         next_role_fault;
	reg         next_role_leader;
	reg         next_manual_role_en;
	reg         next_manual_role_leader;
	reg         pd_full;
	reg         pd_half;
	reg         next_pd_full;
	reg         next_pd_half;
	reg  [15:0] next_rdata;

	// decoded events
	wire        rd_status;
	wire        wr_ctrl;
	wire        an_en_rise;
	wire        an_done_rise;
	wire        forced_clash;
	wire        fail_event;
	wire        pass_event;
	wire        fail_reach;
	wire        fault_set;
	wire        fault_soft_clear;
	wire        idle_qualified;

	// receiver and partner levels come from another domain
	gls_sync #(
		.WIDTH(4)
	) u_sync (
		.clk      (clk),
		.arst_n   (arst_n),
		.async_in ({loc_rcvr_ok, rem_rcvr_ok, partner_gig_full_duplex_able, partner_gig_half_duplex_able}),
		.sync_out (pin_sync)
	);

	// bit order follows the concatenation at the synchroniser input
	assign loc_ok_s  = pin_sync[3];
	assign rem_ok_s  = pin_sync[2];
	assign lp_full_s = pin_sync[1];
	assign lp_half_s = pin_sync[0];

	// event decode
	assign rd_status        = mgmt_rd && (mgmt_addr == `GLS_ADDR_LINK_STATUS);
	assign wr_ctrl          = mgmt_wr && (mgmt_addr == `GLS_ADDR_CTRL);
	assign an_en_rise       = an_enable && !an_enable_d;
	assign an_done_rise     = an_complete && !an_complete_d;
	assign forced_clash     = manual_role_en && partner_manual_en &&
		(manual_role_leader == partner_manual_leader);
	assign fail_event       = resolve_done && resolve_fail;
	assign pass_event       = resolve_done && !resolve_fail;
	// only the step onto the limit sets the fault; a count resting there must not re-set it after a read
	assign fail_reach       = fail_event && (fail_count != `GLS_FAIL_LIMIT) &&
		(next_fail_count == `GLS_FAIL_LIMIT);
	assign fault_set        = fail_reach || forced_clash || extra_fault;
	assign fault_soft_clear = rd_status || an_en_rise || an_done_rise;
	assign idle_qualified   = receiving_idle && transmit_mode_indication;

	// idle error counter; a status read empties it
	gls_idle_counter u_idle (
		.clk          (clk),
		.arst_n       (arst_n),
		.count_enable (idle_qualified),
		.symbol_error (rx_symbol_error),
		.read_clear   (rd_status),
		.pcs_reset    (pcs_reset),
		.count        (idle_count)
	);

	// manual role control lives in register nine
	always @* begin
		next_manual_role_en     = manual_role_en;
		next_manual_role_leader = manual_role_leader;
		if (wr_ctrl) begin
			next_manual_role_en     = mgmt_wdata[`GLS_BIT_MAN_EN];
			next_manual_role_leader = mgmt_wdata[`GLS_BIT_MAN_VAL];
		end
	end

	// both bits default to zero, so the negotiated role applies after reset
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			manual_role_en     <= 1'b0;
			manual_role_leader <= 1'b0;
		end else begin
			manual_role_en     <= next_manual_role_en;
			manual_role_leader <= next_manual_role_leader;
		end
	end

	// failed resolutions since the last restart; the count rests at the limit
	always @* begin
		next_fail_count = fail_count;
		if (an_en_rise || pma_reset) begin
			next_fail_count = `GLS_FAIL_ZERO;
		end else if (fail_event && fail_count != `GLS_FAIL_LIMIT) begin
			next_fail_count = fail_count + 3'h1;
		end
	end

	// fault latch: a set wins over the soft clears so no event is lost; a pma reset wins over all
	always @* begin
		next_role_fault = role_fault;
		if (fault_soft_clear) begin
			next_role_fault = 1'b0;
		end
		if (fault_set) begin
			next_role_fault = 1'b1;
		end
		if (pma_reset) begin
			next_role_fault = 1'b0;
		end
	end

	// the role bit moves only on a successful resolution or a pma reset
	always @* begin
		next_role_leader = role_leader;
		if (pma_reset) begin
			next_role_leader = 1'b0;
		end else if (pass_event) begin
			next_role_leader = manual_role_en ? manual_role_leader : resolved_leader;
		end
	end

	// edge detectors start low, so an enable already high at reset release counts as a start
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			an_enable_d   <= 1'b0;
			an_complete_d <= 1'b0;
		end else begin
			an_enable_d   <= an_enable;
			an_complete_d <= an_complete;
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fail_count <= `GLS_FAIL_ZERO;
		end else begin
			fail_count <= next_fail_count;
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			role_fault <= 1'b0;
		end else begin
			role_fault <= next_role_fault;
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			role_leader <= 1'b0;
		end else begin
			role_leader <= next_role_leader;
		end
	end

	// partner ability held at zero until the page has arrived
	always @* begin
		next_pd_full = pd_full;
		next_pd_half = pd_half;
		if (an_en_rise) begin
			next_pd_full = 1'b0;
			next_pd_half = 1'b0;
		end else if (page_received) begin
			next_pd_full = lp_full_s;
			next_pd_half = lp_half_s;
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pd_full <= 1'b0;
			pd_half <= 1'b0;
		end else begin
			pd_full <= next_pd_full;
			pd_half <= next_pd_half;
		end
	end

	// read mux; of these fields, writes touch only the two manual role bits of register nine
	always @* begin
		next_rdata = `GLS_DATA_ZERO;
		case (mgmt_addr)
			`GLS_ADDR_LINK_STATUS: begin
				next_rdata[`GLS_BIT_FAULT]  = role_fault;
				next_rdata[`GLS_BIT_ROLE]   = role_leader;
				next_rdata[`GLS_BIT_LOC_RX] = loc_ok_s;
				next_rdata[`GLS_BIT_REM_RX] = rem_ok_s;
				next_rdata[`GLS_BIT_LP_FD]  = pd_full;
				next_rdata[`GLS_BIT_LP_HD]  = pd_half;
				next_rdata[`GLS_CNT_MSB:0]  = idle_count;
			end
			`GLS_ADDR_EXT_CAP: begin
				next_rdata[15:`GLS_EXT_NIBBLE_LSB] = ext_status_nibble;
			end
			`GLS_ADDR_CTRL: begin
				next_rdata[`GLS_BIT_MAN_EN]  = manual_role_en;
				next_rdata[`GLS_BIT_MAN_VAL] = manual_role_leader;
			end
			default: begin
				// unmapped addresses read as zero
				next_rdata = `GLS_DATA_ZERO;
			end
		endcase
	end

	// read data holds until the next read, so a slow station can still pick it up
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mgmt_rvalid <= 1'b0;
		end else begin
			mgmt_rvalid <= mgmt_rd;
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mgmt_rdata <= `GLS_DATA_ZERO;
		end else if (mgmt_rd) begin
			mgmt_rdata <= next_rdata;
		end
	end
endmodule // gls_status

// ===== hdl/gls_sync.v
module gls_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             clk,
	input  wire             arst_n,
	// async levels in, synchronised out
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta     <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule // gls_sync

// ===== testbench/gls_chk_assertions.sv
module gls_chk (
	// clock and reset
	input wire logic	clk,
	input wire logic	arst_n,
	// management
	input wire logic	mgmt_rd,
	input wire logic [4:0]	mgmt_addr,
	input wire logic [15:0]	mgmt_rdata,
	input wire logic	mgmt_rvalid,
	// fault sources
	input wire logic	pma_reset,
	input wire logic	extra_fault,
	input wire logic	resolve_done,
	input wire logic	resolve_fail,
	input wire logic	resolved_leader,
	input wire logic	partner_manual_en,
	input wire logic	partner_manual_leader,
	// role outputs
	input wire logic	manual_role_en,
	input wire logic	manual_role_leader,
	input wire logic	role_leader,
	input wire logic	role_fault
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire st_rd = mgmt_rd && mgmt_addr == 5'h0a;
	a_read_shows_fault: assert property (st_rd |=> mgmt_rdata[15] == $past(role_fault)) else $error("fault bit");
	a_read_shows_role: assert property (st_rd |=> mgmt_rdata[14] == $past(role_leader)) else $error("role bit");
	a_reserved_zero: assert property (st_rd |=> mgmt_rvalid && mgmt_rdata[9:8] == 2'h0) else $error("reserved");
	a_read_clears_fault: assert property (st_rd && !extra_fault && !partner_manual_en && !resolve_done
		|=> !role_fault) else $error("fault kept after read");
	a_pma_clears_fault: assert property (pma_reset |=> !role_fault) else $error("fault kept after pma");
	a_extra_sets_fault: assert property (extra_fault && !pma_reset |=> role_fault) else $error("no fault");
	a_clash_sets_fault: assert property (manual_role_en && partner_manual_en && !pma_reset
		&& manual_role_leader == partner_manual_leader |=> role_fault) else $error("no clash fault");
	a_read_clears_count: assert property (st_rd ##1 st_rd |=> mgmt_rdata[7:0] == 8'h00) else $error("count");
	a_role_follows: assert property (resolve_done && !resolve_fail && !manual_role_en && !pma_reset
		|=> role_leader == $past(resolved_leader)) else $error("role not resolved");
endmodule // gls_chk

bind gls_status gls_chk chk_u (.clk, .arst_n, .mgmt_rd, .mgmt_addr, .mgmt_rdata, .mgmt_rvalid, .pma_reset,
	.extra_fault, .resolve_done, .resolve_fail, .resolved_leader, .partner_manual_en, .partner_manual_leader,
	.manual_role_en, .manual_role_leader, .role_leader, .role_fault);

// ===== testbench/gls_mgmt.sv
module gls_mgmt (
	// clock and read return
	input wire logic	clk,
	input wire logic [15:0]	mgmt_rdata,
	// requests
	output logic		mgmt_rd,
	output logic		mgmt_wr,
	output logic [4:0]	mgmt_addr,
	output logic [15:0]	mgmt_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {mgmt_rd, mgmt_wr, mgmt_addr, mgmt_wdata} = '0;
	// strobe held n edges; idle address is inverted so a stale value is never mistaken for a request
	task automatic rd(input logic [4:0] a, input int n, output logic [15:0] q);
		@(negedge clk);
		mgmt_addr = a;
		mgmt_rd = 1'b1;
		repeat (n) @(negedge clk);
		mgmt_rd = 1'b0;
		mgmt_addr = ~a;
		q = mgmt_rdata;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(negedge clk);
		{mgmt_wr, mgmt_addr, mgmt_wdata} = {1'b1, a, v};
		@(negedge clk);
		{mgmt_wr, mgmt_addr, mgmt_wdata} = {1'b0, ~a, ~v};
	endtask
endmodule // gls_mgmt

// ===== testbench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, arst_n = 0, pma_reset = 0, pcs_reset = 0, an_enable = 0, page_received = 0;
	logic resolve_done = 0, resolve_fail = 0, pm_en = 0, pm_ld = 0, extra_fault = 0, an_done = 0, res_ld = 0;
	logic loc_ok = 0, rem_ok = 0, cap_fd = 0, cap_hd = 0, rx_idle = 0, tx_mode = 0, rx_err = 0;
	logic mgmt_rd, mgmt_wr, rvalid, man_en, man_ld, role_leader, role_fault;
	logic [4:0] mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata, d;
	int mismatches = 0, checks_done = 0;
	always #5 clk = ~clk;
	gls_status dut_u (.clk, .arst_n, .mgmt_rd, .mgmt_wr, .mgmt_addr, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid(rvalid),
		.pma_reset, .pcs_reset, .an_enable, .an_complete(an_done), .page_received, .resolve_done, .resolve_fail,
		.resolved_leader(res_ld), .partner_manual_en(pm_en), .partner_manual_leader(pm_ld), .extra_fault,
		.loc_rcvr_ok(loc_ok), .rem_rcvr_ok(rem_ok), .partner_gig_full_duplex_able(cap_fd),
		.partner_gig_half_duplex_able(cap_hd), .receiving_idle(rx_idle), .transmit_mode_indication(tx_mode),
		.rx_symbol_error(rx_err), .ext_status_nibble(4'h9), .manual_role_en(man_en),
		.manual_role_leader(man_ld), .role_leader, .role_fault);
	gls_mgmt mgmt_u (.clk, .mgmt_rdata, .mgmt_rd, .mgmt_wr, .mgmt_addr, .mgmt_wdata);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse_fault;
		extra_fault = 1;
		cyc(1);
		extra_fault = 0;
	endtask
	task automatic t_fault;
		{resolve_done, resolve_fail} = 2'b11;
		repeat (7) cyc(1);
		resolve_done = 0;
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h8000, 16'h8000);
		chk({15'h0000, role_fault}, 16'h0000);
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h8000, 16'h0000);
		pulse_fault();
		chk({15'h0000, role_fault}, 16'h0001);
		pma_reset = 1;
		cyc(1);
		pma_reset = 0;
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h8000, 16'h0000);
		pulse_fault();
		an_enable = 1;
		cyc(1);
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h8000, 16'h0000);
		pulse_fault();
		an_done = 1;
		cyc(1);
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h8000, 16'h0000);
		$display("t_fault done");
	endtask
	task automatic t_idle;
		{rx_idle, tx_mode, rx_err} = 3'b111;
		cyc(5);
		rx_err = 0;
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h00ff, 16'h0005);
		{tx_mode, rx_err} = 2'b01;
		cyc(4);
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h00ff, 16'h0000);
		tx_mode = 1;
		cyc(300);
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h00ff, 16'h00ff);
		mgmt_u.rd(5'h0a, 2, d); chk(d & 16'h00ff, 16'h0000);
		cyc(3);
		{pcs_reset, rx_err} = 2'b10;
		cyc(1);
		pcs_reset = 0;
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h00ff, 16'h0000);
		$display("t_idle done");
	endtask
	task automatic t_status;
		{loc_ok, rem_ok, cap_fd, cap_hd} = 4'hf;
		cyc(4);
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h3f00, 16'h3000);
		page_received = 1;
		cyc(4);
		mgmt_u.wr(5'h0a, 16'h0000);
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h3f00, 16'h3c00);
		{loc_ok, cap_fd} = 2'b00;
		cyc(4);
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h3f00, 16'h1400);
		mgmt_u.rd(5'h0f, 1, d); chk(d & 16'hf000, 16'h9000);
		mgmt_u.rd(5'h1f, 1, d); chk(d, 16'h0000);
		$display("t_status done");
	endtask
	task automatic t_manual;
		mgmt_u.wr(5'h09, 16'h1800);
		chk({14'h0000, man_en, man_ld}, 16'h0003);
		mgmt_u.rd(5'h09, 1, d); chk(d & 16'h1800, 16'h1800);
		{pm_en, pm_ld} = 2'b11;
		cyc(2);
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h8000, 16'h8000);
		pm_en = 0;
		{resolve_done, resolve_fail} = 2'b10;
		cyc(1);
		resolve_done = 0;
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h4000, 16'h4000);
		mgmt_u.wr(5'h09, 16'h0800);
		resolve_done = 1;
		cyc(1);
		resolve_done = 0;
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h4000, 16'h0000);
		{resolve_done, res_ld} = 2'b11;
		cyc(1);
		resolve_done = 0;
		mgmt_u.rd(5'h0a, 1, d); chk(d & 16'h4000, 16'h4000);
		$display("t_manual done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		cyc(6);
		arst_n = 1;
		t_fault();
		t_idle();
		t_status();
		t_manual();
		test_done();
	end
	initial begin
		#50000;
		mismatches++;
		test_done();
	end
endmodule // tb
